//--- rtl/mcs_pkg.sv
// constants and types for the measurement chain sequencer
// assumes a single 50 MHz system clock
package mcs_pkg;
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned TICK_S = 1;
    localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_S;
    localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
    localparam int unsigned FILT_W = 16;
    localparam int unsigned VAL_W = 16;
    localparam logic [3:0] STAGE_COUNT = 4'hA;

    typedef enum logic [3:0] {
        MCS_IDLE    = 4'b0000,
        MCS_FILTER  = 4'b0001,
        MCS_RANGE   = 4'b0010,
        MCS_SCALE   = 4'b0011,
        MCS_SUMM    = 4'b0100,
        MCS_HOLD    = 4'b0101,
        MCS_ALARM   = 4'b0110,
        MCS_CONTROL = 4'b0111,
        MCS_RECORD  = 4'b1000,
        MCS_SETOUT  = 4'b1001,
        MCS_OSCALE  = 4'b1010
    } mcs_stage_t;
endpackage

//--- rtl/mcs_debounce.sv
// level filter for one digital input
// assumes the input level is already synchronised to i_clock
`timescale 1ns/1ns
`default_nettype none
module mcs_debounce #(
    parameter int unsigned MS_CYC = mcs_pkg::MS_CYCLES,
    parameter int unsigned FW = mcs_pkg::FILT_W
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_level,
    input wire logic [FW-1:0] i_filter_ms,
    output logic o_level
);
    import mcs_pkg::*;
    logic [31:0] cyc_q;
    logic [FW-1:0] ms_q;
    logic lvl_q;

    // always running, no enable from the sequencer
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            cyc_q <= 32'h0;
            ms_q <= '0;
            lvl_q <= 1'b0;
        end else if (i_filter_ms == '0) begin
            lvl_q <= i_level;
            cyc_q <= 32'h0;
            ms_q <= '0;
        end else if (i_level == lvl_q) begin
            cyc_q <= 32'h0;
            ms_q <= '0;
        end else if (cyc_q == 32'(MS_CYC - 1)) begin
            cyc_q <= 32'h0;
            // change accepted only once stable for the whole filter time
            if (ms_q + 1'b1 >= i_filter_ms) begin
                lvl_q <= i_level;
                ms_q <= '0;
            end else begin
                ms_q <= ms_q + 1'b1;
            end
        end else begin
            cyc_q <= cyc_q + 32'h1;
        end
    end
    assign o_level = lvl_q;

    property p_passthru;
        @(posedge i_clock) disable iff (!i_nrst)
        (i_filter_ms == '0) |=> (o_level == $past(i_level));
    endproperty
    a_passthru: assert property (p_passthru) else $error("raw level not passed");

    property p_hold_short;
        @(posedge i_clock) disable iff (!i_nrst)
        (i_filter_ms != '0 && i_level == o_level) |=> $stable(o_level);
    endproperty
    a_hold_short: assert property (p_hold_short) else $error("level changed without cause");
endmodule
`default_nettype wire

//--- rtl/mcs_top.sv
// measurement chain sequencer: runs the ten processing stages per measurement
// assumes measure/record strobes are one-cycle pulses on i_clock; digital pin is asynchronous
// Operation
// - input filter runs all the time, measurement or not
// - stages run filter, range, scale, summarise, hold, alarm, control, record, output, rescale
// - a measurement strobe starts the chain once, run to completion; strobes during one chain queue a single run
// - digital mode also runs the chain on each second tick that finds it idle with no measurement waiting, skipping control
// - filtered digital level is sampled once per second
// - digital alarms and triggers checked each second only while no measurement chain is running or waiting
// - zero filter time passes raw level; nonzero suppresses glitches
// - values stored only on record-interval instants; setpoint updated on every run
// - invalid value replaced by last valid one before alarm check
// - digital level change accepted after stable for filter time in ms
// - raw value outside mode range raises a range violation flag
`timescale 1ns/1ns
`default_nettype none
module mcs_top #(
    parameter int unsigned TICK_CYC = mcs_pkg::TICK_CYCLES,
    parameter int unsigned MS_CYC = mcs_pkg::MS_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_digital_mode,
    input wire logic i_digital_pin,
    input wire logic i_invert,
    input wire logic [mcs_pkg::FILT_W-1:0] i_filter_ms,
    input wire logic i_measure,
    input wire logic i_record,
    input wire logic [mcs_pkg::VAL_W-1:0] i_raw,
    input wire logic i_raw_invalid,
    input wire logic [mcs_pkg::VAL_W-1:0] i_range_lo,
    input wire logic [mcs_pkg::VAL_W-1:0] i_range_hi,
    input wire logic [mcs_pkg::VAL_W-1:0] i_alarm_hi,
    output logic o_busy,
    output mcs_pkg::mcs_stage_t o_stage,
    output logic o_tick,
    output logic o_level,
    output logic o_range_err,
    output logic [mcs_pkg::VAL_W-1:0] o_value,
    output logic o_alarm,
    output logic o_control,
    output logic o_record_we,
    output logic [mcs_pkg::VAL_W-1:0] o_record_data,
    output logic [mcs_pkg::VAL_W-1:0] o_setpoint
);
    import mcs_pkg::*;

    logic pin_s1_q, pin_s2_q;
    logic filt_level;
    logic [31:0] tb_q;
    logic tick_q;
    logic samp_q;
    mcs_stage_t stage_q;
    logic run_ctl_q;
    logic rec_pend_q;
    logic meas_pend_q;
    logic [VAL_W-1:0] val_q, last_valid_q, setpt_q;
    logic range_q, alarm_q, ctl_q, we_q;
    logic [VAL_W-1:0] rec_q;

    function automatic mcs_stage_t next_stage(input mcs_stage_t s, input logic ctl);
        case (s)
            MCS_ALARM: next_stage = ctl ? MCS_CONTROL : MCS_RECORD;
            MCS_OSCALE: next_stage = MCS_IDLE;
            default: next_stage = mcs_stage_t'(s + 4'h1);
        endcase
    endfunction

    // two flops before the pin is read
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
        end else begin
            pin_s1_q <= i_digital_pin;
            pin_s2_q <= pin_s1_q;
        end
    end

    mcs_debounce #(.MS_CYC(MS_CYC), .FW(FILT_W)) u_filt (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_level(pin_s2_q ^ i_invert),
        .i_filter_ms(i_filter_ms),
        .o_level(filt_level)
    );

    // free-running timebase
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            tb_q <= 32'h0;
            tick_q <= 1'b0;
        end else if (tb_q == 32'(TICK_CYC - 1)) begin
            tb_q <= 32'h0;
            tick_q <= 1'b1;
        end else begin
            tb_q <= tb_q + 32'h1;
            tick_q <= 1'b0;
        end
    end

    // once-per-second level sample; pulses under a second may be missed
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            samp_q <= 1'b0;
        end else if (tick_q) begin
            samp_q <= filt_level;
        end
    end

    // measurements arriving mid-chain wait, second ticks are dropped; measurement wins over the second tick
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            stage_q <= MCS_IDLE;
            run_ctl_q <= 1'b0;
            meas_pend_q <= 1'b0;
        end else begin
            if (stage_q == MCS_IDLE && (i_measure || meas_pend_q)) begin
                stage_q <= MCS_FILTER;
                run_ctl_q <= 1'b1;
                meas_pend_q <= 1'b0;
            end else if (stage_q == MCS_IDLE && tick_q && i_digital_mode) begin
                stage_q <= MCS_FILTER;
                run_ctl_q <= 1'b0;
                meas_pend_q <= i_measure;
            end else begin
                if (stage_q != MCS_IDLE) begin
                    stage_q <= next_stage(stage_q, run_ctl_q);
                end
                if (i_measure && stage_q != MCS_IDLE) begin
                    meas_pend_q <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            rec_pend_q <= 1'b0;
        end else if (i_record) begin
            rec_pend_q <= 1'b1; // set wins over the clear
        end else if (stage_q == MCS_RECORD) begin
            rec_pend_q <= 1'b0;
        end
    end

    // datapath per stage
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            val_q <= '0;
            last_valid_q <= '0;
            range_q <= 1'b0;
            alarm_q <= 1'b0;
            ctl_q <= 1'b0;
            we_q <= 1'b0;
            rec_q <= '0;
            setpt_q <= '0;
        end else begin
            we_q <= 1'b0;
            case (stage_q)
                MCS_FILTER: val_q <= i_digital_mode ? VAL_W'(samp_q) : i_raw;
                MCS_RANGE: range_q <= !i_digital_mode && (val_q < i_range_lo || val_q > i_range_hi);
                MCS_HOLD: begin
                    if (i_raw_invalid && !i_digital_mode) begin
                        val_q <= last_valid_q;
                    end else begin
                        last_valid_q <= val_q;
                    end
                end
                MCS_ALARM: alarm_q <= (val_q > i_alarm_hi);
                MCS_CONTROL: ctl_q <= alarm_q;
                MCS_RECORD: begin
                    if (rec_pend_q) begin
                        we_q <= 1'b1;
                        rec_q <= val_q;
                    end
                end
                MCS_SETOUT: setpt_q <= VAL_W'(ctl_q);
                default: ;
            endcase
        end
    end

    assign o_busy = (stage_q != MCS_IDLE);
    assign o_stage = stage_q;
    assign o_tick = tick_q;
    assign o_level = samp_q;
    assign o_range_err = range_q;
    assign o_value = val_q;
    assign o_alarm = alarm_q;
    assign o_control = ctl_q;
    assign o_record_we = we_q;
    assign o_record_data = rec_q;
    assign o_setpoint = setpt_q;

    property p_order;
        @(posedge i_clock) disable iff (!i_nrst)
        (stage_q == MCS_FILTER) |=> (stage_q == MCS_RANGE) ##1 (stage_q == MCS_SCALE) ##1 (stage_q == MCS_SUMM);
    endproperty
    a_order: assert property (p_order) else $error("stage order broken");

    property p_start;
        @(posedge i_clock) disable iff (!i_nrst)
        (stage_q == MCS_IDLE && i_measure) |=> (stage_q == MCS_FILTER && run_ctl_q);
    endproperty
    a_start: assert property (p_start) else $error("measurement did not start chain");

    property p_full_run;
        @(posedge i_clock) disable iff (!i_nrst)
        (stage_q == MCS_FILTER && run_ctl_q) |-> ##10 (stage_q == MCS_IDLE);
    endproperty
    a_full_run: assert property (p_full_run) else $error("chain length wrong");

    property p_skip_ctl;
        @(posedge i_clock) disable iff (!i_nrst)
        (stage_q == MCS_ALARM && !run_ctl_q) |=> (stage_q == MCS_RECORD);
    endproperty
    a_skip_ctl: assert property (p_skip_ctl) else $error("control ran on second tick");

    property p_tick_run;
        @(posedge i_clock) disable iff (!i_nrst)
        (tick_q && i_digital_mode && stage_q == MCS_IDLE && !i_measure && !meas_pend_q) |=> (stage_q == MCS_FILTER);
    endproperty
    a_tick_run: assert property (p_tick_run) else $error("second tick missed");

    property p_sample;
        @(posedge i_clock) disable iff (!i_nrst)
        !tick_q |=> $stable(samp_q);
    endproperty
    a_sample: assert property (p_sample) else $error("level sampled off tick");

    property p_record;
        @(posedge i_clock) disable iff (!i_nrst)
        o_record_we |-> $past(rec_pend_q) && $past(stage_q == MCS_RECORD);
    endproperty
    a_record: assert property (p_record) else $error("record outside interval");

    property p_hold;
        @(posedge i_clock) disable iff (!i_nrst)
        (stage_q == MCS_HOLD && i_raw_invalid && !i_digital_mode) |=> (val_q == $past(last_valid_q));
    endproperty
    a_hold: assert property (p_hold) else $error("invalid value not replaced");

    property p_range;
        @(posedge i_clock) disable iff (!i_nrst)
        (stage_q == MCS_RANGE && !i_digital_mode && val_q < i_range_lo) |=> range_q;
    endproperty
    a_range: assert property (p_range) else $error("range violation not flagged");

    property p_tick_period;
        @(posedge i_clock) disable iff (!i_nrst)
        tick_q |=> !tick_q;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick longer than a cycle");
endmodule
`default_nettype wire

//--- verif/mcs_sensor_model.sv
// sensor-side model: the digital pin source of one universal input
// assumes the bench's system clock; the pin is asynchronous to the design
`timescale 1ns/1ns
`default_nettype none
module mcs_sensor_model (
    input wire logic i_clock,
    output logic o_pin
);
    initial o_pin = 1'b0;
    // level is held until the bench asks for a change
    task automatic set_level(input logic lvl);
        @(posedge i_clock);
        o_pin <= lvl;
    endtask
    // short drop, well under one second on purpose
    task automatic glitch(input int n);
        logic keep;
        keep = o_pin;
        @(posedge i_clock);
        o_pin <= ~keep;
        repeat (n) @(posedge i_clock);
        o_pin <= keep;
    endtask
endmodule
`default_nettype wire

//--- verif/measurement_chain_sequencer_bench.sv
// self-checking bench for mcs_top with a shortened one-second timebase
// assumes the sensor model drives the digital pin
`timescale 1ns/1ns
`default_nettype none
module measurement_chain_sequencer_bench;
    import mcs_pkg::*;
    localparam int unsigned TICKS = 100;
    logic i_clock, i_nrst, i_digital_mode, i_invert, i_measure, i_record, i_raw_invalid;
    logic [15:0] i_filter_ms, i_raw, i_range_lo, i_range_hi, i_alarm_hi, seed, last_valid;
    logic [15:0] o_value, o_record_data, o_setpoint;
    logic o_busy, o_tick, o_level, o_range_err, o_alarm, o_control, o_record_we;
    wire pin;
    mcs_stage_t o_stage;
    int mismatches, compares;
    longint t0;
    logic ctl_seen;
    mcs_stage_t seq [10] = '{MCS_FILTER, MCS_RANGE, MCS_SCALE, MCS_SUMM, MCS_HOLD,
                             MCS_ALARM, MCS_CONTROL, MCS_RECORD, MCS_SETOUT, MCS_OSCALE};

    mcs_sensor_model i_mcs_sensor_model (.i_clock(i_clock), .o_pin(pin));
    mcs_top #(.TICK_CYC(TICKS), .MS_CYC(5)) i_mcs_top (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_digital_mode(i_digital_mode), .i_digital_pin(pin),
        .i_invert(i_invert), .i_filter_ms(i_filter_ms), .i_measure(i_measure), .i_record(i_record),
        .i_raw(i_raw), .i_raw_invalid(i_raw_invalid), .i_range_lo(i_range_lo), .i_range_hi(i_range_hi),
        .i_alarm_hi(i_alarm_hi), .o_busy(o_busy), .o_stage(o_stage), .o_tick(o_tick), .o_level(o_level),
        .o_range_err(o_range_err), .o_value(o_value), .o_alarm(o_alarm), .o_control(o_control),
        .o_record_we(o_record_we), .o_record_data(o_record_data), .o_setpoint(o_setpoint));

    always #10 i_clock = ~i_clock;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic exp_range(input logic [15:0] v);
        return (v < i_range_lo) || (v > i_range_hi);
    endfunction
    function automatic logic exp_alarm(input logic [15:0] v);
        return v > i_alarm_hi;
    endfunction

    task automatic results();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // hold value tracked here, never read back from the design
    task automatic measure(input logic [15:0] raw, input logic bad, input logic rec);
        logic [15:0] ev;
        ev = bad ? last_valid : raw;
        if (!bad) last_valid = raw;
        @(posedge i_clock);
        i_raw <= raw;
        i_raw_invalid <= bad;
        i_record <= rec;
        i_measure <= 1'b1;
        @(posedge i_clock);
        i_measure <= 1'b0;
        i_record <= 1'b0;
        for (int k = 0; k < 10; k++) begin
            #1;
            chk("stage", 16'(seq[k]), 16'(o_stage));
            if (k == 1) chk("value", raw, o_value);
            if (k == 2) chk("range_err", 16'(exp_range(raw)), 16'(o_range_err));
            if (k == 6) chk("alarm", 16'(exp_alarm(ev)), 16'(o_alarm));
            if (k == 7) chk("control", 16'(exp_alarm(ev)), 16'(o_control));
            if (k == 8) chk("record_we", 16'(rec), 16'(o_record_we));
            if (k == 8 && rec) chk("record_data", ev, o_record_data);
            if (k == 9) chk("setpoint", 16'(exp_alarm(ev)), o_setpoint);
            @(posedge i_clock);
        end
        #1;
        chk("idle", 16'(MCS_IDLE), 16'(o_stage));
        chk("held_value", ev, o_value);
    endtask
    task automatic wait_tick();
        for (int n = 0; n < 300; n++) begin
            @(posedge i_clock);
            #1;
            if (o_tick === 1'b1) return;
        end
        mismatches++;
        $display("[ERR] tick expected 1 seen 0");
        results();
    endtask
    // first tick lets the level settle, the second run is judged
    task automatic tick_run(input logic lvl);
        int busy_n;
        logic ctl;
        busy_n = 0;
        ctl = 1'b0;
        wait_tick();
        wait_tick();
        for (int k = 0; k < 14; k++) begin
            if (o_busy === 1'b1) busy_n++;
            if (o_stage === MCS_CONTROL) ctl = 1'b1;
            if (k == 1) chk("level", 16'(lvl), 16'(o_level));
            @(posedge i_clock);
            #1;
        end
        chk("tick_run_len", 16'(9), 16'(busy_n));
        chk("no_control", 16'(0), 16'(ctl));
        chk("digital_alarm", 16'(lvl), 16'(o_alarm));
    endtask

    initial begin
        {i_clock, i_nrst, i_digital_mode, i_invert, i_measure, i_record, i_raw_invalid} = '0;
        {i_filter_ms, i_raw, i_alarm_hi} = '0;
        i_range_lo = 16'h0100;
        i_range_hi = 16'h0F00;
        seed = 16'h0052;
        last_valid = 16'h0000;
        repeat (3) @(posedge i_clock);
        #1;
        chk("reset_stage", 16'(MCS_IDLE), 16'(o_stage));
        chk("reset_busy", 16'h0000, 16'(o_busy));
        @(posedge i_clock);
        i_nrst <= 1'b1;
        i_alarm_hi <= 16'h0800;
        measure(16'h0500, 1'b0, 1'b0);
        measure(16'h0050, 1'b0, 1'b1);
        measure(16'hFFFF, 1'b1, 1'b1);
        measure(16'h0F00, 1'b0, 1'b0);
        measure(16'h0100, 1'b0, 1'b1);
        for (int r = 0; r < 8; r++) begin
            seed = lfsr(seed);
            measure(seed, seed[0] & seed[5], seed[3]);
        end
        wait_tick();
        t0 = $time;
        wait_tick();
        chk("tick_period", 16'(TICKS), 16'(($time - t0) / 20));
        @(posedge i_clock);
        i_digital_mode <= 1'b1;
        i_alarm_hi <= 16'h0000;
        i_mcs_sensor_model.set_level(1'b1);
        tick_run(1'b1);
        @(posedge i_clock);
        i_invert <= 1'b1;
        tick_run(1'b0);
        @(posedge i_clock);
        i_invert <= 1'b0;
        wait_tick();
        wait_tick();
        repeat (90) @(posedge i_clock);
        i_mcs_sensor_model.glitch(15);
        #1;
        chk("raw_glitch", 16'h0000, 16'(o_level));
        @(posedge i_clock);
        i_filter_ms <= 16'h0002;
        wait_tick();
        wait_tick();
        repeat (94) @(posedge i_clock);
        i_mcs_sensor_model.glitch(6);
        #1;
        chk("filtered_glitch", 16'h0001, 16'(o_level));
        i_mcs_sensor_model.set_level(1'b0);
        tick_run(1'b0);
        // measurement during a tick run waits, then runs with control
        wait_tick();
        @(posedge i_clock);
        i_measure <= 1'b1;
        @(posedge i_clock);
        i_measure <= 1'b0;
        ctl_seen = 1'b0;
        for (int n = 0; n < 30; n++) begin
            @(posedge i_clock);
            #1;
            if (o_stage === MCS_CONTROL) ctl_seen = 1'b1;
        end
        chk("queued_control", 16'h0001, 16'(ctl_seen));
        results();
    end
endmodule
`default_nettype wire
